// ---- hdl/sdcc_pkg.sv ----
// shared constants for the sdram command, address and clock-gate port
`default_nettype none
package sdcc_pkg;
	localparam int CLK_NS = 10;
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int DQ_W = 16;
	localparam int ADDR_W = 12;
	localparam int BANK_N = 4;
	localparam int BANK_WORDS = 1048576;
	localparam int WADDR_W = BANK_W + ROW_W + COL_W;
	localparam int MEM_WORDS = BANK_N * BANK_WORDS;
	// command codes as {rowStrobeN, colStrobeN, writeStrobeN}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_BST = 3'h6;
	localparam logic [2:0] CMD_NOP = 3'h7;
	// mode word fields
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WB_BIT = 9;
	localparam int AP_BIT = 10;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [11:0] MODE_RST = 12'h020;
	localparam logic [11:0] CTRL_MODE = 12'h020;
	localparam int MRS_CYC = 2;
	localparam int READ_CL = 2;
	// power-up wait and refresh spacing
	localparam int PWRUP_US = 200;
	localparam int PWRUP_CYC_DEF = PWRUP_US * 1000 / CLK_NS;
	localparam int REFRESH_MS = 64;
	localparam int REFRESH_ROWS = 4096;
	localparam int REFI_CYC = REFRESH_MS * 1000000 / REFRESH_ROWS / CLK_NS;
	localparam int INIT_REFS = 2;
	localparam int GAP_CYC = 3;
	localparam int RFC_CYC = 7;
	localparam int WAKE_CYC = 1;
endpackage
`default_nettype wire

// ---- hdl/sdcc_if.sv ----
// pins between the memory controller and the sdram, with data bus resolution
`default_nettype none
interface sdcc_if;
	import sdcc_pkg::*;
	logic cke;
	logic csN;
	logic rasN;
	logic casN;
	logic weN;
	logic [ADDR_W-1:0] addr;
	logic [BANK_W-1:0] ba;
	logic [1:0] dqm;
	logic [DQ_W-1:0] ctrlDq;
	logic ctrlDqOe;
	logic [DQ_W-1:0] memDq;
	logic [1:0] memDqOe;
	wire [DQ_W-1:0] dq;
	// each byte lane is driven by whichever end enables it; an idle lane reads as zero
	genvar b;
	for (b = 0; b < 2; b++) begin : lane
		assign dq[b*8+:8] = ctrlDqOe ? ctrlDq[b*8+:8] :
			memDqOe[b] ? memDq[b*8+:8] : 8'h00;
	end
	modport ctrl (output cke, csN, rasN, casN, weN, addr, ba, dqm, ctrlDq, ctrlDqOe,
		input dq);
	modport mem (input cke, csN, rasN, casN, weN, addr, ba, dqm, dq,
		output memDq, memDqOe);
endinterface
`default_nettype wire

// ---- hdl/sdcc_mem.sv ----
// sdram device end: command decode, banks, bursts, clock gate and power-down
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
module sdcc_mem
	import sdcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	sdcc_if.mem bus,
	output logic powerDown,
	output logic clkSuspended,
	output logic [BANK_N-1:0] bankOpen,
	output logic [ADDR_W-1:0] modeWord
);
	typedef struct packed {
		logic live;
		logic pdn;
		logic [ADDR_W-1:0] mode;
		logic [1:0] mrsBusy;
		logic [BANK_N-1:0] active;
		logic [BANK_N-1:0][ROW_W-1:0] openRow;
		logic bRd;
		logic bWr;
		logic [BANK_W-1:0] bBank;
		logic [COL_W-1:0] bStart;
		logic [COL_W-1:0] bIdx;
		logic [8:0] bLeft;
		logic [2:0] pipeV;
		logic [2:0][DQ_W-1:0] pipeD;
		logic [1:0][1:0] dqmD;
	} sdcc_mem_s;

	sdcc_mem_s r;
	sdcc_mem_s n;
	logic [DQ_W-1:0] mem [0:MEM_WORDS-1];
	logic [2:0] cmd;
	logic cmdOk;
	logic wrBeat;
	logic [WADDR_W-1:0] beatAddr;

	////////////////////////////////////////////////////////////////////////
	// burst length in beats; full page walks the whole open row
	function automatic logic [8:0] blLen(input logic [2:0] code);
		case (code)
			BL_1: blLen = 9'h001;
			BL_2: blLen = 9'h002;
			BL_4: blLen = 9'h004;
			BL_8: blLen = 9'h008;
			BL_PAGE: blLen = 9'h100;
			default: blLen = 9'h001;
		endcase
	endfunction

	// column of a beat, wrapping inside the aligned burst block
	function automatic logic [COL_W-1:0] burstCol(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] idx, input logic [8:0] len, input logic inter);
		logic [COL_W-1:0] m;
		m = 8'(len - 9'h001);
		if (inter && len != 9'h100) begin
			burstCol = (start & ~m) | ((start ^ idx) & m);
		end else begin
			burstCol = (start & ~m) | (8'(start + idx) & m);
		end
	endfunction

	assign cmd = {bus.rasN, bus.casN, bus.weN};
	// deselect and the mode-program settle time both mask the decoder
	assign cmdOk = r.live && !bus.csN && r.mrsBusy == 2'h0;

	////////////////////////////////////////////////////////////////////////
	// next-state logic; nothing but the gate sample and the power-down flag moves while suspended
	always_comb begin
		logic curRd;
		logic curWr;
		logic [BANK_W-1:0] curBank;
		logic [COL_W-1:0] curStart;
		logic [COL_W-1:0] curIdx;
		logic [8:0] curLeft;
		logic [8:0] len;
		logic [COL_W-1:0] col;
		curRd = 1'b0;
		curWr = 1'b0;
		curBank = r.bBank;
		curStart = r.bStart;
		curIdx = r.bIdx;
		curLeft = r.bLeft;
		len = blLen(r.mode[MODE_BL_LSB+:3]);
		col = '0;
		n = r;
		wrBeat = 1'b0;
		beatAddr = '0;
		n.live = bus.cke;
		n.pdn = !bus.cke && (r.pdn || (r.live && r.active == '0));
		if (r.live) begin
			if (r.mrsBusy != 2'h0) begin
				n.mrsBusy = r.mrsBusy - 2'h1;
			end
			// read pipe and the two-cycle read mask delay
			n.pipeV = {r.pipeV[1:0], 1'b0};
			n.pipeD = {r.pipeD[1:0], r.pipeD[0]};
			n.dqmD = {r.dqmD[0], bus.dqm};
			curRd = r.bRd;
			curWr = r.bWr;
			if (cmdOk) begin
				case (cmd)
					CMD_ACT: begin
						n.active[bus.ba] = 1'b1;
						n.openRow[bus.ba] = bus.addr;
					end
					CMD_RD, CMD_WR: begin
						if (r.active[bus.ba]) begin
							curRd = cmd == CMD_RD;
							curWr = cmd == CMD_WR;
							curBank = bus.ba;
							curStart = bus.addr[COL_W-1:0];
							curIdx = '0;
							curLeft = (cmd == CMD_WR && r.mode[MODE_WB_BIT]) ? 9'h001 : len;
						end
					end
					CMD_PRE: begin
						for (int b = 0; b < BANK_N; b++) begin
							if (bus.addr[AP_BIT] || bus.ba == 2'(b)) begin
								n.active[b] = 1'b0;
							end
						end
						if (bus.addr[AP_BIT] || bus.ba == r.bBank) begin
							curRd = 1'b0;
							curWr = 1'b0;
						end
					end
					CMD_MRS: begin
						if (r.active == '0 && !r.bRd && !r.bWr) begin
							n.mode = bus.addr;
							n.mrsBusy = 2'(MRS_CYC - 1);
						end
					end
					CMD_BST: begin
						curRd = 1'b0;
						curWr = 1'b0;
					end
					default: begin
					end
				endcase
			end
			// one beat per running cycle, address from the programmed order
			if (curRd || curWr) begin
				col = burstCol(curStart, curIdx, len, r.mode[MODE_BT_BIT]);
				beatAddr = {curBank, n.openRow[curBank], col};
				wrBeat = curWr;
				n.pipeV[0] = curRd;
				n.pipeD[0] = mem[beatAddr];
				n.bIdx = curIdx + 8'h01;
				n.bLeft = curLeft - 9'h001;
				n.bRd = curRd && curLeft > 9'h001;
				n.bWr = curWr && curLeft > 9'h001;
				n.bBank = curBank;
				n.bStart = curStart;
			end else begin
				n.bRd = 1'b0;
				n.bWr = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.mode <= MODE_RST;
		end else begin
			r <= n;
		end
	end

	// array write per byte lane; a set mask keeps the stored byte
	// one process owns the whole array, so the lanes loop inside it
	always_ff @(posedge mclk) begin
		for (int g = 0; g < 2; g++) begin
			if (wrBeat && !bus.dqm[g]) begin
				mem[beatAddr][g*8+:8] <= bus.dq[g*8+:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data out after the programmed latency, masked per byte
	always_comb begin
		logic sel;
		sel = r.mode[MODE_CL_LSB+:3] == CL_3;
		bus.memDq = sel ? r.pipeD[2] : r.pipeD[1];
		bus.memDqOe = {2{sel ? r.pipeV[2] : r.pipeV[1]}} & ~r.dqmD[1];
	end

	assign powerDown = r.pdn;
	assign clkSuspended = !r.live;
	assign bankOpen = r.active;
	assign modeWord = r.mode;
endmodule
`default_nettype wire

// ---- hdl/sdcc_ctrl.sv ----
// memory controller end: power-up, refresh, single-word access, power-down
`default_nettype none
module sdcc_ctrl
	import sdcc_pkg::*;
#(
	parameter int PWRUP_CYC = PWRUP_CYC_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	sdcc_if.ctrl bus,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [WADDR_W-1:0] reqAddr,
	input wire logic [DQ_W-1:0] reqData,
	input wire logic [1:0] reqMask,
	output logic reqReady,
	output logic rdValid,
	output logic [DQ_W-1:0] rdData,
	input wire logic pdReq,
	output logic initDone,
	output logic inPowerDown
);
	typedef enum logic [3:0] {
		S_BOOT = 4'h0, S_PWRUP = 4'h1, S_PREALL = 4'h2, S_INITREF = 4'h3,
		S_MRS = 4'h4, S_IDLE = 4'h5, S_RW = 4'h6, S_RDWAIT = 4'h7,
		S_PRE = 4'h8, S_PDN = 4'h9, S_WAKE = 4'ha
	} sdcc_st_e;

	typedef struct packed {
		sdcc_st_e st;
		logic [14:0] cnt;
		logic [10:0] refCnt;
		logic refDue;
		logic [1:0] refLeft;
		logic done;
		logic wr;
		logic [WADDR_W-1:0] addr;
		logic [DQ_W-1:0] data;
		logic [1:0] mask;
		logic cke;
		logic csN;
		logic [2:0] cmd;
		logic [ADDR_W-1:0] pa;
		logic [BANK_W-1:0] ba;
		logic [1:0] dqm;
		logic [DQ_W-1:0] dqOut;
		logic dqOe;
		logic rdV;
		logic [DQ_W-1:0] rdD;
	} sdcc_ctrl_s;

	sdcc_ctrl_s r;
	sdcc_ctrl_s n;

	////////////////////////////////////////////////////////////////////////
	// sequencer; every command is followed by a gap of no-ops whose length is set per command
	always_comb begin
		logic refTick;
		logic refTake;
		refTick = r.done && r.refCnt == 11'(REFI_CYC - 1);
		refTake = 1'b0;
		n = r;
		n.cmd = CMD_NOP;
		n.dqOe = 1'b0;
		n.rdV = 1'b0;
		n.refCnt = refTick ? '0 : (r.done ? r.refCnt + 11'h001 : '0);
		if (r.cnt != '0) begin
			n.cnt = r.cnt - 15'h0001;
		end else begin
			case (r.st)
				S_BOOT: begin
					n.cnt = 15'(PWRUP_CYC);
					n.st = S_PWRUP;
				end
				S_PWRUP: begin
					n.cmd = CMD_PRE;
					n.pa = 12'h400; // all banks
					n.cnt = 15'(GAP_CYC);
					n.refLeft = 2'(INIT_REFS);
					n.st = S_PREALL;
				end
				S_PREALL, S_INITREF: begin
					n.cmd = CMD_REF;
					n.cnt = 15'(RFC_CYC);
					n.refLeft = r.refLeft - 2'h1;
					n.st = (r.refLeft == 2'h1) ? S_MRS : S_INITREF;
				end
				S_MRS: begin
					n.cmd = CMD_MRS;
					n.pa = CTRL_MODE;
					n.ba = '0;
					n.cnt = 15'(MRS_CYC);
					n.done = 1'b1;
					n.dqm = 2'h0;
					n.st = S_IDLE;
				end
				S_IDLE: begin
					if (r.refDue) begin
						n.cmd = CMD_REF;
						refTake = 1'b1;
						n.cnt = 15'(RFC_CYC);
					end else if (reqValid) begin
						n.wr = reqWrite;
						n.addr = reqAddr;
						n.data = reqData;
						n.mask = reqMask;
						n.cmd = CMD_ACT;
						n.ba = reqAddr[WADDR_W-1-:BANK_W];
						n.pa = reqAddr[COL_W+:ROW_W];
						n.cnt = 15'(GAP_CYC);
						n.st = S_RW;
					end else if (pdReq) begin
						n.cke = 1'b0; // banks are all precharged here
						n.csN = 1'b1;
						n.st = S_PDN;
					end
				end
				S_RW: begin
					n.cmd = r.wr ? CMD_WR : CMD_RD;
					n.pa = {4'h0, r.addr[COL_W-1:0]};
					n.dqOut = r.data;
					n.dqOe = r.wr;
					n.dqm = r.wr ? r.mask : 2'h0;
					n.cnt = r.wr ? 15'(GAP_CYC) : 15'(READ_CL);
					n.st = r.wr ? S_PRE : S_RDWAIT;
				end
				S_RDWAIT, S_PRE: begin
					n.rdV = r.st == S_RDWAIT;
					n.rdD = r.st == S_RDWAIT ? bus.dq : r.rdD;
					n.cmd = CMD_PRE;
					n.pa = 12'h000;
					n.dqm = 2'h0;
					n.cnt = 15'(GAP_CYC);
					n.st = S_IDLE;
				end
				S_PDN: begin
					if (r.refDue || !pdReq) begin
						n.cke = 1'b1;
						n.csN = 1'b0;
						n.cnt = 15'(WAKE_CYC);
						n.st = S_WAKE;
					end
				end
				S_WAKE: begin
					n.st = S_IDLE;
				end
				default: begin
					n.st = S_BOOT;
				end
			endcase
		end
		// a tick in the cycle of its own clear still leaves refresh owed
		n.refDue = refTick || (r.refDue && !refTake);
	end

	////////////////////////////////////////////////////////////////////////
	// state register; gate and mask held high through power-up
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.cke <= 1'b1;
			r.cmd <= CMD_NOP;
			r.dqm <= 2'h3;
		end else begin
			r <= n;
		end
	end

	assign bus.cke = r.cke;
	assign bus.csN = r.csN;
	assign {bus.rasN, bus.casN, bus.weN} = r.cmd;
	assign bus.addr = r.pa;
	assign bus.ba = r.ba;
	assign bus.dqm = r.dqm;
	assign bus.ctrlDq = r.dqOut;
	assign bus.ctrlDqOe = r.dqOe;
	assign reqReady = r.st == S_IDLE && r.cnt == '0 && !r.refDue;
	assign rdValid = r.rdV;
	assign rdData = r.rdD;
	assign initDone = r.done;
	assign inPowerDown = r.st == S_PDN;
endmodule
`default_nettype wire

// ---- testbench/sdcc_chk_sva.sv ----
// checker on the pins between the controller and the memory
`default_nettype none
module sdcc_chk
	import sdcc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [1:0] dqm,
	input wire logic ctrlDqOe,
	input wire logic [1:0] memDqOe,
	input wire logic powerDown,
	input wire logic clkSuspended,
	input wire logic [BANK_N-1:0] bankOpen,
	input wire logic [ADDR_W-1:0] modeWord
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////
	// a command counts only when selected and the gate was high last edge
	logic [2:0] cmd;
	logic live;
	assign cmd = {rasN, casN, weN};
	assign live = !csN && !clkSuspended;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	property p_pd_entry;
		(!cke && !clkSuspended && bankOpen == 4'h0) |=> powerDown;
	endproperty
	a_pd_entry: assert property (p_pd_entry)
		else $error("power-down not entered");
	property p_pd_exit;
		(powerDown && cke) |=> !powerDown;
	endproperty
	a_pd_exit: assert property (p_pd_exit)
		else $error("power-down not left");
	// the edge after a low gate must change nothing
	property p_frozen;
		!cke |=> ##1 ($stable(bankOpen) && $stable(modeWord));
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("state moved while gated");
	property p_deselect;
		csN |=> ($stable(bankOpen) && $stable(modeWord));
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("deselected command acted");
	property p_act_open;
		(live && cmd == CMD_ACT) |=> bankOpen[$past(ba)];
	endproperty
	a_act_open: assert property (p_act_open)
		else $error("activated bank not open");
	property p_mode_load;
		(live && cmd == CMD_MRS && bankOpen == 4'h0) |=> modeWord == $past(addr);
	endproperty
	a_mode_load: assert property (p_mode_load)
		else $error("mode value not loaded");
	// mask at the read edge governs which lanes drive two edges later
	property p_rd_lat;
		(live && cmd == CMD_RD && bankOpen[ba] && modeWord[6:4] == 3'h2)
			|-> ##2 (memDqOe == ~$past(dqm, 2));
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read data lanes wrong");
	property p_one_driver;
		!(ctrlDqOe && memDqOe != 2'b00);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive data");
	property p_cke_lead;
		(!csN && cmd != CMD_NOP) |-> $past(cke);
	endproperty
	a_cke_lead: assert property (p_cke_lead)
		else $error("command without gate lead");
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench: controller and memory joined, user side driven
`default_nettype none
module testbench
	import sdcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic rst;
	logic reqValid;
	logic reqWrite;
	logic [WADDR_W-1:0] reqAddr;
	logic [DQ_W-1:0] reqData;
	logic [1:0] reqMask;
	logic reqReady;
	logic rdValid;
	logic [DQ_W-1:0] rdData;
	logic pdReq;
	logic initDone;
	logic inPowerDown;
	logic powerDown;
	logic clkSuspended;
	logic [BANK_N-1:0] bankOpen;
	logic [ADDR_W-1:0] modeWord;
	logic [15:0] got;
	int errorCnt = 0;
	int checked = 0;
	int refSeen = 0;
	int refBase = 0;
	// selectors of the outputs that waitFor can watch
	localparam int SEL_READY = 0;
	localparam int SEL_RDV = 1;
	localparam int SEL_INIT = 2;
	localparam int SEL_PDC = 3;
	localparam int SEL_PDM = 4;
	// top corner of every bank, then row-only and column-only neighbours
	logic [WADDR_W-1:0] addrTab [7] = '{{2'h0, 12'hFFF, 8'hFF}, {2'h1, 12'hFFF, 8'hFF},
		{2'h2, 12'hFFF, 8'hFF}, {2'h3, 12'hFFF, 8'hFF}, {2'h1, 12'h000, 8'h00},
		{2'h1, 12'h800, 8'h00}, {2'h1, 12'h000, 8'h80}};
	////////////////////////////////////////////////////////////////////////
	sdcc_if i_sdcc_if ();
	sdcc_ctrl #(.PWRUP_CYC(20)) i_sdcc_ctrl (.mclk(mclk), .rst(rst), .bus(i_sdcc_if.ctrl),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
		.reqMask(reqMask), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
		.pdReq(pdReq), .initDone(initDone), .inPowerDown(inPowerDown));
	sdcc_mem i_sdcc_mem (.mclk(mclk), .rst(rst), .bus(i_sdcc_if.mem), .powerDown(powerDown),
		.clkSuspended(clkSuspended), .bankOpen(bankOpen), .modeWord(modeWord));
	sdcc_chk i_sdcc_chk (.mclk(mclk), .rst(rst), .cke(i_sdcc_if.cke), .csN(i_sdcc_if.csN),
		.rasN(i_sdcc_if.rasN), .casN(i_sdcc_if.casN), .weN(i_sdcc_if.weN),
		.addr(i_sdcc_if.addr), .ba(i_sdcc_if.ba), .dqm(i_sdcc_if.dqm),
		.ctrlDqOe(i_sdcc_if.ctrlDqOe), .memDqOe(i_sdcc_if.memDqOe), .powerDown(powerDown),
		.clkSuspended(clkSuspended), .bankOpen(bankOpen), .modeWord(modeWord));
	////////////////////////////////////////////////////////////////////////
	always #5 mclk = ~mclk;
	// refresh commands seen on the pins, counted for the idle test
	always @(posedge mclk) begin
		if (i_sdcc_if.cke && !i_sdcc_if.csN
			&& {i_sdcc_if.rasN, i_sdcc_if.casN, i_sdcc_if.weN} == CMD_REF) begin
			refSeen <= refSeen + 1;
		end
	end
	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// watched outputs, read at an edge before that edge's updates land
	function automatic logic probe(input int sel);
		case (sel)
			SEL_READY: probe = reqReady;
			SEL_RDV: probe = rdValid;
			SEL_INIT: probe = initDone;
			SEL_PDC: probe = inPowerDown;
			default: probe = powerDown;
		endcase
	endfunction
	// bounded wait; the output is read afresh each edge, a copied argument would never move
	task automatic waitFor(input string what, input int sel, input logic val, input int lim);
		int n;
		n = 0;
		while (probe(sel) !== val) begin
			@(posedge mclk);
			n++;
			if (n > lim) begin
				errorCnt++;
				$display("[FAIL] %s expected %b seen %b", what, val, probe(sel));
				return;
			end
		end
	endtask
	// request held until an edge sees ready; one idle edge after keeps drivers apart
	task automatic access(input logic w, input logic [WADDR_W-1:0] a, input logic [15:0] d,
		input logic [1:0] m);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		reqMask <= m;
		@(posedge mclk);
		waitFor("reqReady", SEL_READY, 1'b1, 3000);
		reqValid <= 1'b0;
		if (!w) begin
			waitFor("rdValid", SEL_RDV, 1'b1, 40);
			got = rdData;
		end
		@(posedge mclk);
	endtask
	task automatic rd(input logic [WADDR_W-1:0] a, input logic [15:0] exp);
		access(1'b0, a, 16'h0000, 2'b00);
		check("rdData", exp, got);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200_000;
		errorCnt++;
		$display("[FAIL] watchdog expected finish seen timeout");
		printVerdict();
	end
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = '0;
		reqData = 16'h0000;
		reqMask = 2'b00;
		pdReq = 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		waitFor("initDone", SEL_INIT, 1'b1, 500);
		check("modeWord", {4'h0, CTRL_MODE}, {4'h0, modeWord});
		$display("test init ended");
		for (int i = 0; i < 7; i++) access(1'b1, addrTab[i], 16'h1000 + 16'(i), 2'b00);
		for (int i = 0; i < 7; i++) rd(addrTab[i], 16'h1000 + 16'(i));
		$display("test banks and addressing ended");
		access(1'b1, addrTab[4], 16'h1234, 2'b00);
		access(1'b1, addrTab[4], 16'hABCD, 2'b01);
		rd(addrTab[4], 16'hAB34);
		access(1'b1, addrTab[4], 16'h5678, 2'b10);
		rd(addrTab[4], 16'hAB78);
		$display("test byte masks ended");
		pdReq <= 1'b1;
		waitFor("inPowerDown", SEL_PDC, 1'b1, 3000);
		waitFor("powerDown", SEL_PDM, 1'b1, 10);
		repeat (4) @(posedge mclk);
		check("powerDown", 16'h0001, {15'h0, powerDown});
		check("clkSuspended", 16'h0001, {15'h0, clkSuspended});
		check("bankOpen", 16'h0000, {12'h0, bankOpen});
		pdReq <= 1'b0;
		waitFor("inPowerDown", SEL_PDC, 1'b0, 50);
		waitFor("powerDown", SEL_PDM, 1'b0, 10);
		rd(addrTab[4], 16'hAB78);
		rd(addrTab[3], 16'h1003);
		$display("test power-down ended");
		// a full refresh interval of idle time must bring at least one refresh
		refBase = refSeen;
		repeat (REFI_CYC + 40) @(posedge mclk);
		check("refSeen", 16'h0001, {15'h0, refSeen > refBase});
		rd(addrTab[0], 16'h1000);
		$display("test refresh ended");
		printVerdict();
	end
endmodule
`default_nettype wire
